// *** core/abh_pkg.sv ***
// Functional notes
// - Address strobe starts cycle; byte strobes mark data
// - No timeout; wait states until acknowledge
// - Write: direction low together with strobe, before data
// - Write: byte strobes only after data valid
// - Acknowledge must drop promptly after strobes drop
// - Bus error termination raises exception next cycle
// - Legal release order reruns same cycle
// - Illegal release order traps to vector zero
// - Stop still held after normal end stretches next
// - Fault still held ends next cycle as error
package abh_pkg;
    // Bus states of the cycle engine, one-hot
    typedef enum logic [8:0] {
        ABH_IDLE  = 9'h001,
        ABH_ADDR  = 9'h002,
        ABH_STRB  = 9'h004,
        ABH_DATA  = 9'h008,
        ABH_WAIT  = 9'h010,
        ABH_LATE  = 9'h020,
        ABH_END   = 9'h040,
        ABH_HALT  = 9'h080,
        ABH_STALL = 9'h100
    } abh_state_e;

    // Outcome codes reported with done
    localparam logic [1:0] ABH_RES_OK = 2'h0;
    localparam logic [1:0] ABH_RES_BUS_ERR = 2'h1;
    localparam logic [1:0] ABH_RES_ILLEGAL = 2'h2;

    // Vector number taken on an illegal release order
    localparam logic [7:0] ABH_ILLEGAL_VECTOR = 8'h00;

    // Vector shown while no trap is pending; a fresh start restores it
    localparam logic [7:0] ABH_NO_VECTOR = 8'hFF;

    // Reset values
    localparam logic [1:0] ABH_SYNC_RESET = 2'h0;
    localparam logic [3:0] ABH_RETRY_RESET = 4'h0;
endpackage : abh_pkg

// *** core/abh_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser, one per bit
module abh_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Raw and synchronised levels
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] sync_out
);
    // Per-bit flop pair; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic [1:0] stage;
            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    stage <= abh_pkg::ABH_SYNC_RESET;
                end else begin
                    stage <= {stage[0], raw_in[i]};
                end
            end
            assign sync_out[i] = stage[1];
        end
    endgenerate
endmodule // abh_sync
`default_nettype wire

// *** core/abh_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
// Master side of the asynchronous bus-cycle handshake
module abh_cycle #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16,
    parameter bit LATE_TERM = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Request from the core
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    input wire logic req_upper_in,
    input wire logic req_lower_in,
    // Answer to the core
    output logic req_ready_out,
    output logic done_out,
    output logic [1:0] result_out,
    output logic [DATA_W-1:0] rdata_out,
    output logic [7:0] trap_vector_out,
    // Bus pins, strobes active low
    output logic address_strobe_n_out,
    output logic upper_byte_strobe_n_out,
    output logic lower_byte_strobe_n_out,
    output logic read_write_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_out,
    input wire logic [DATA_W-1:0] data_in,
    // Termination pins, active low, asynchronous
    input wire logic transfer_ack_n_in,
    input wire logic bus_fault_in_n_in,
    input wire logic stop_request_n_in
);
    // All state in one record
    typedef struct packed {
        abh_pkg::abh_state_e state;
        logic as_n;
        logic uds_n;
        logic lds_n;
        logic rw;
        logic oe;
        logic write;
        logic upper;
        logic lower;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic done;
        logic [1:0] result;
        logic [7:0] vector;
        logic retry;       // Retry pending, waiting for release
        logic fault_seen;  // Fault released before stop during retry
    } abh_state_s;

    abh_state_s cur;
    abh_state_s next_cur;

    // Synchronised termination inputs, active high
    logic [2:0] sync;
    logic ack;
    logic fault;
    logic stop;

    // Inputs cross into the clock domain first
    abh_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .raw_in({~stop_request_n_in, ~bus_fault_in_n_in, ~transfer_ack_n_in}),
        .sync_out(sync)
    );
    assign ack = sync[0];
    assign fault = sync[1];
    assign stop = sync[2];

    // Next-state logic for the whole engine
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        unique case (cur.state)
            abh_pkg::ABH_IDLE: begin
                next_cur.ready = 1'b1;
                // Held stop from last cycle stretches the start
                if (req_valid_in && cur.ready && !stop) begin
                    next_cur.ready = 1'b0;
                    next_cur.write = req_write_in;
                    next_cur.addr = req_addr_in;
                    next_cur.wdata = req_wdata_in;
                    next_cur.upper = req_upper_in;
                    next_cur.lower = req_lower_in;
                    next_cur.state = abh_pkg::ABH_ADDR;
                end else if (req_valid_in && cur.ready) begin
                    next_cur.ready = 1'b0;
                    next_cur.write = req_write_in;
                    next_cur.addr = req_addr_in;
                    next_cur.wdata = req_wdata_in;
                    next_cur.upper = req_upper_in;
                    next_cur.lower = req_lower_in;
                    next_cur.state = abh_pkg::ABH_STALL;
                end
            end
            abh_pkg::ABH_STALL: begin
                // Wait for stop to drop before driving the cycle
                if (!stop) begin
                    next_cur.state = abh_pkg::ABH_ADDR;
                end
            end
            abh_pkg::ABH_ADDR: begin
                // Strobe opens the cycle; reads strobe bytes at once
                next_cur.as_n = 1'b0;
                next_cur.rw = !cur.write;
                // Clear any old trap so a stale vector is never reported
                next_cur.vector = abh_pkg::ABH_NO_VECTOR;
                if (!cur.write) begin
                    next_cur.uds_n = !cur.upper;
                    next_cur.lds_n = !cur.lower;
                end
                next_cur.state = abh_pkg::ABH_STRB;
            end
            abh_pkg::ABH_STRB: begin
                // Data driven only after direction already low
                next_cur.oe = cur.write;
                next_cur.state = abh_pkg::ABH_DATA;
            end
            abh_pkg::ABH_DATA: begin
                // Byte strobes follow valid write data
                if (cur.write) begin
                    next_cur.uds_n = !cur.upper;
                    next_cur.lds_n = !cur.lower;
                end
                next_cur.state = abh_pkg::ABH_WAIT;
            end
            abh_pkg::ABH_WAIT: begin
                // Any fault ends the cycle; stop with it retries
                if (fault && stop) begin
                    next_cur.retry = 1'b1;
                    next_cur.state = abh_pkg::ABH_END;
                end else if (fault) begin
                    next_cur.result = abh_pkg::ABH_RES_BUS_ERR;
                    next_cur.state = abh_pkg::ABH_END;
                end else if (ack) begin
                    next_cur.rdata = data_in;
                    next_cur.result = abh_pkg::ABH_RES_OK;
                    next_cur.state = LATE_TERM ? abh_pkg::ABH_LATE : abh_pkg::ABH_END;
                end
                // Otherwise one more wait state, no limit
            end
            abh_pkg::ABH_LATE: begin
                // Late fault one clock after acknowledge
                if (fault && stop) begin
                    next_cur.retry = 1'b1;
                end else if (fault) begin
                    next_cur.result = abh_pkg::ABH_RES_BUS_ERR;
                end
                next_cur.state = abh_pkg::ABH_END;
            end
            abh_pkg::ABH_END: begin
                // Drop strobes and data; slave must release ack
                next_cur.as_n = 1'b1;
                next_cur.uds_n = 1'b1;
                next_cur.lds_n = 1'b1;
                next_cur.oe = 1'b0;
                next_cur.rw = 1'b1;
                if (cur.retry) begin
                    next_cur.fault_seen = 1'b0;
                    next_cur.state = abh_pkg::ABH_HALT;
                end else begin
                    // Error reported as exception next cycle
                    next_cur.done = 1'b1;
                    next_cur.state = abh_pkg::ABH_IDLE;
                end
            end
            abh_pkg::ABH_HALT: begin
                // Watch release order of fault and stop
                if (!fault && !stop && !cur.fault_seen) begin
                    // Stop released first or together: illegal
                    next_cur.retry = 1'b0;
                    next_cur.result = abh_pkg::ABH_RES_ILLEGAL;
                    next_cur.vector = abh_pkg::ABH_ILLEGAL_VECTOR;
                    next_cur.done = 1'b1;
                    next_cur.state = abh_pkg::ABH_IDLE;
                end else if (fault && !stop) begin
                    next_cur.retry = 1'b0;
                    next_cur.result = abh_pkg::ABH_RES_ILLEGAL;
                    next_cur.vector = abh_pkg::ABH_ILLEGAL_VECTOR;
                    next_cur.done = 1'b1;
                    next_cur.state = abh_pkg::ABH_IDLE;
                end else if (!fault && stop) begin
                    next_cur.fault_seen = 1'b1;
                end else if (!fault && !stop) begin
                    // Legal release: rerun the same cycle
                    next_cur.retry = 1'b0;
                    next_cur.state = abh_pkg::ABH_ADDR;
                end
            end
            default: begin
                next_cur.state = abh_pkg::ABH_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cur.state <= abh_pkg::ABH_IDLE;
            cur.as_n <= 1'b1;
            cur.uds_n <= 1'b1;
            cur.lds_n <= 1'b1;
            cur.rw <= 1'b1;
            cur.oe <= 1'b0;
            cur.write <= 1'b0;
            cur.upper <= 1'b0;
            cur.lower <= 1'b0;
            cur.addr <= '0;
            cur.wdata <= '0;
            cur.rdata <= '0;
            cur.ready <= 1'b0;
            cur.done <= 1'b0;
            cur.result <= abh_pkg::ABH_RES_OK;
            cur.vector <= abh_pkg::ABH_NO_VECTOR;
            cur.retry <= 1'b0;
            cur.fault_seen <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the record
    assign req_ready_out = cur.ready;
    assign done_out = cur.done;
    assign result_out = cur.result;
    assign rdata_out = cur.rdata;
    assign trap_vector_out = cur.vector;
    assign address_strobe_n_out = cur.as_n;
    assign upper_byte_strobe_n_out = cur.uds_n;
    assign lower_byte_strobe_n_out = cur.lds_n;
    assign read_write_out = cur.rw;
    assign addr_out = cur.addr;
    assign data_out = cur.wdata;
    assign data_oe_out = cur.oe;
endmodule // abh_cycle
`default_nettype wire

// *** bench/abh_cycle_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pin-level watch on the master side of the handshake
module abh_cycle_checker #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Core side and bus pins
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire logic done_out,
    input wire logic [1:0] result_out,
    input wire logic [7:0] trap_vector_out,
    input wire logic address_strobe_n_out,
    input wire logic upper_byte_strobe_n_out,
    input wire logic lower_byte_strobe_n_out,
    input wire logic read_write_out,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_out,
    input wire logic transfer_ack_n_in,
    input wire logic bus_fault_in_n_in,
    input wire logic stop_request_n_in
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire logic strb_idle = upper_byte_strobe_n_out && lower_byte_strobe_n_out; // Both byte strobes high
    sequence s_take; req_valid_in && req_ready_out && $past(stop_request_n_in, 2); endsequence
    sequence s_lone_fault; $fell(bus_fault_in_n_in) && stop_request_n_in && !address_strobe_n_out; endsequence
    sequence s_good_release; $rose(stop_request_n_in) && $past(bus_fault_in_n_in) && !req_ready_out; endsequence
    sequence s_bad_release; $rose(bus_fault_in_n_in) && $past(stop_request_n_in) && !$past(stop_request_n_in, 2); endsequence
    // Taken request with stop not held: address strobe must fall within two clocks
    a_strobe_on_take: assert property (s_take |-> ##[1:2] !address_strobe_n_out)
        else $error("no address strobe after take");
    a_rw_before_data: assert property ($rose(data_oe_out) |-> $past(!read_write_out) && !address_strobe_n_out)
        else $error("data driven before direction");
    a_strobe_after_data: assert property ($fell(strb_idle) && !read_write_out |-> $past(data_oe_out))
        else $error("write strobe before data");
    a_write_data_held: assert property (!strb_idle && !read_write_out |-> data_oe_out && $stable(data_out))
        else $error("write data moved under strobe");
    a_waits_for_ack: assert property ((!address_strobe_n_out && transfer_ack_n_in && bus_fault_in_n_in)[*3]
        |=> !done_out)
        else $error("cycle ended without termination");
    a_lone_fault_error: assert property (s_lone_fault ##1 (!bus_fault_in_n_in && stop_request_n_in)[*2]
        |-> ##[0:4] (done_out && result_out == abh_pkg::ABH_RES_BUS_ERR))
        else $error("fault did not end as bus error");
    // Stop seen through the synchroniser keeps the strobe back
    a_stop_holds_off: assert property ($fell(address_strobe_n_out) |-> $past(stop_request_n_in, 4))
        else $error("cycle started under held stop");
    a_legal_rerun: assert property (s_good_release |-> ##[1:8] !address_strobe_n_out)
        else $error("no rerun after legal release");
    a_illegal_trap: assert property (s_bad_release |-> ##[0:6] (done_out && trap_vector_out ==
        abh_pkg::ABH_ILLEGAL_VECTOR && result_out == abh_pkg::ABH_RES_ILLEGAL))
        else $error("bad release order not trapped");
endmodule // abh_cycle_checker
bind abh_cycle abh_cycle_checker #(.DATA_W(DATA_W)) i_abh_cycle_checker (.*);
`default_nettype wire

// *** bench/abh_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Slave stand-in: answers, faults and retries as the bench commands
module abh_slave_model (
    // Clock and scenario controls
    input wire logic clk_sys_in,
    input wire logic [2:0] mode_in,
    input wire logic [3:0] dly_in,
    // Bus from the master
    input wire logic address_strobe_n_in,
    input wire logic upper_byte_strobe_n_in,
    input wire logic lower_byte_strobe_n_in,
    input wire logic read_write_in,
    input wire logic [23:0] addr_in,
    input wire logic [15:0] data_in,
    // Termination and read data
    output logic transfer_ack_n_out,
    output logic bus_fault_in_n_out,
    output logic stop_request_n_out,
    output logic [15:0] data_out,
    // Observations for the bench
    output logic [7:0] starts_out,
    output logic [15:0] wr_word_out
);
    logic [15:0] noise = 16'h0; // Floating bus never shows stale data
    logic data_ok = 1'b0; // Read data trails the acknowledge by a clock
    logic [2:0] m; // Behaviour of this cycle
    logic retry = 1'b0; // A rerun is answered plainly
    initial starts_out = 8'h0;
    always @(negedge address_strobe_n_in) starts_out <= starts_out + 8'h1;
    always @(negedge clk_sys_in) noise <= noise + 16'h1357;
    // Word decoded from the address alone, strobe or not
    assign data_out = (data_ok && read_write_in) ? addr_in[15:0] ^ 16'hC35A : noise;
    // Modes: 0 ack, 1 fault, 2 ack+fault, 3 late fault, 4 retry, 5 late retry, 6 bad release
    // Mode 7: ack with stop held past the end, so the next start is stretched
    initial begin
        {transfer_ack_n_out, bus_fault_in_n_out, stop_request_n_out} = 3'h7;
        wr_word_out = 16'h0;
        forever begin
            @(negedge clk_sys_in iff !(upper_byte_strobe_n_in && lower_byte_strobe_n_in));
            repeat (dly_in) @(negedge clk_sys_in); // Slow memory
            m = retry ? 3'h0 : mode_in;
            if (!read_write_in) wr_word_out = data_in; // Latched before answering
            transfer_ack_n_out = !(m inside {3'h0, 3'h2, 3'h3, 3'h5, 3'h7});
            bus_fault_in_n_out = !(m inside {3'h1, 3'h2, 3'h4, 3'h6});
            stop_request_n_out = !(m inside {3'h4, 3'h6, 3'h7});
            @(negedge clk_sys_in);
            data_ok = !transfer_ack_n_out; // Data valid one clock after ack
            if (m == 3'h3 || m == 3'h5) begin // Late fault one clock after ack
                bus_fault_in_n_out = 1'b0;
                stop_request_n_out = (m == 3'h3);
            end
            while (!address_strobe_n_in) @(negedge clk_sys_in);
            transfer_ack_n_out = 1'b1; // Dropped right after strobes
            data_ok = 1'b0;
            if (m == 3'h6) begin // Wrong order on purpose: stop first
                stop_request_n_out = 1'b1;
                @(negedge clk_sys_in);
            end
            bus_fault_in_n_out = 1'b1;
            repeat (2) @(negedge clk_sys_in); // Stop outlasts fault
            stop_request_n_out = 1'b1;
            retry = (m == 3'h4 || m == 3'h5);
        end
    end
endmodule // abh_slave_model
`default_nettype wire

// *** bench/test_abh_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
// Core requests against every slave behaviour, corner cases then random
module test_abh_cycle;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic req_upper_in = 1'b1;
    logic req_lower_in = 1'b1;
    logic [23:0] req_addr_in = 24'h0;
    logic [15:0] req_wdata_in = 16'h0;
    logic req_ready_out, done_out, address_strobe_n_out, upper_byte_strobe_n_out, lower_byte_strobe_n_out;
    logic read_write_out, data_oe_out, transfer_ack_n_in, bus_fault_in_n_in, stop_request_n_in;
    logic [1:0] result_out;
    logic [7:0] trap_vector_out, starts;
    logic [23:0] addr_out;
    logic [15:0] rdata_out, data_out, data_in, wr_word;
    logic [2:0] mode = 3'h0; // Slave behaviour
    logic [3:0] dly = 4'h0; // Slave wait states
    int mismatches = 0;
    int tests_run = 0;
    abh_cycle i_abh_cycle (.*);
    abh_slave_model i_abh_slave_model (.clk_sys_in(clk_sys_in), .mode_in(mode), .dly_in(dly),
        .address_strobe_n_in(address_strobe_n_out), .upper_byte_strobe_n_in(upper_byte_strobe_n_out),
        .lower_byte_strobe_n_in(lower_byte_strobe_n_out), .read_write_in(read_write_out), .addr_in(addr_out),
        .data_in(data_out), .transfer_ack_n_out(transfer_ack_n_in), .bus_fault_in_n_out(bus_fault_in_n_in),
        .stop_request_n_out(stop_request_n_in), .data_out(data_in), .starts_out(starts), .wr_word_out(wr_word));
    initial forever #25 clk_sys_in = ~clk_sys_in; // 20 MHz
    // Outcome each slave behaviour must give
    function automatic logic [1:0] exp_res(input logic [2:0] m);
        if (m inside {3'h1, 3'h2, 3'h3}) return abh_pkg::ABH_RES_BUS_ERR;
        if (m == 3'h6) return abh_pkg::ABH_RES_ILLEGAL;
        return abh_pkg::ABH_RES_OK;
    endfunction
    task automatic check(input string what, input logic [15:0] want, input logic [15:0] seen);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One request, inputs moved at the falling edge, bounded waits
    task automatic run(input logic w, input logic [23:0] a, input logic [15:0] d, input logic [1:0] be,
                       input logic [2:0] m, input logic [3:0] dl);
        logic [7:0] s0;
        logic [15:0] msk;
        logic plain;
        int n;
        s0 = starts;
        msk = {{8{be[1]}}, {8{be[0]}}};
        plain = m inside {3'h0, 3'h4, 3'h5, 3'h7}; // Modes that end in a good transfer
        mode = m;
        dly = dl;
        n = 0;
        while (req_ready_out !== 1'b1 && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
        {req_valid_in, req_write_in, req_addr_in, req_wdata_in, req_upper_in, req_lower_in} = {1'b1, w, a, d, be};
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
        while (done_out !== 1'b1 && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            wrap_up();
        end
        check("result", 16'(exp_res(m)), 16'(result_out));
        check("starts", (m inside {3'h4, 3'h5}) ? 16'h2 : 16'h1, 16'(starts - s0));
        check("vector", (m == 3'h6) ? 16'(abh_pkg::ABH_ILLEGAL_VECTOR) : 16'(abh_pkg::ABH_NO_VECTOR),
            16'(trap_vector_out));
        if (plain && w) check("write", d & msk, wr_word & msk);
        if (plain && !w) check("read", (a[15:0] ^ 16'hC35A) & msk, rdata_out & msk);
    endtask
    initial begin
        void'($urandom(22248));
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        // Each behaviour both ways, no wait and long wait, edge addresses, back to back
        for (int k = 0; k < 32; k++) begin
            run(k[0], k[1] ? 24'hFFFFFF : 24'h000000, 16'hA55A ^ 16'(k), 2'h3, 3'(k / 4), k[1] ? 4'hF : 4'h0);
        end
        for (int k = 0; k < 60; k++) begin
            run(1'($urandom), 24'($urandom), 16'($urandom), 2'($urandom_range(3, 1)), 3'($urandom_range(7, 0)),
                4'($urandom));
        end
        wrap_up();
    end
endmodule // test_abh_cycle
`default_nettype wire
